/* include/rtc_map.svh */
/*
  Register offsets, field positions, reset values and timing counts
  for the real time clock register file.
  Assumes a 20 MHz core clock and a 32.768 kHz crystal input.
*/
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

// ==========================================================
// Register offsets
`define ADDR_YEARS      15'h7fff
`define ADDR_MONTHS     15'h7ffe
`define ADDR_DATE       15'h7ffd
`define ADDR_WEEKDAY    15'h7ffc
`define ADDR_HOURS      15'h7ffb
`define ADDR_MINUTES    15'h7ffa
`define ADDR_SECONDS    15'h7ff9
`define ADDR_TRIM       15'h7ff8
`define ADDR_WATCHDOG   15'h7ff7
`define ADDR_IRQ_CTRL   15'h7ff6
`define ADDR_ALM_DATE   15'h7ff5
`define ADDR_ALM_HOURS  15'h7ff4
`define ADDR_ALM_MIN    15'h7ff3
`define ADDR_ALM_SEC    15'h7ff2
`define ADDR_CENTURIES  15'h7ff1
`define ADDR_FLAGS      15'h7ff0
`define ADDR_BLOCK      11'h7ff

// ==========================================================
// Field positions
`define TRIM_STOP_BIT   7
`define TRIM_SIGN_BIT   5
`define WD_KICK_BIT     7
`define WD_LOCK_BIT     6
`define IRQ_WIE_BIT     7
`define IRQ_AIE_BIT     6
`define IRQ_PFE_BIT     5
`define IRQ_HL_BIT      3
`define IRQ_PL_BIT      2
`define ALM_MASK_BIT    7
`define FLG_WDF_BIT     7
`define FLG_AF_BIT      6
`define FLG_PF_BIT      5
`define FLG_OSC_FAIL_FLAG_BIT    4
`define FLG_CAL_BIT     2
`define FLG_W_BIT       1
`define FLG_R_BIT       0

// ==========================================================
// Reset values
`define RST_TIME        8'h00
`define RST_DAY_ONE     8'h01
`define RST_TRIM        8'h00
`define RST_WATCHDOG    8'h00
`define RST_IRQ_CTRL    8'h08
`define RST_ALARM       8'h80

// ==========================================================
// Timing
`define CLK_HZ          64'd20000000
`define IRQ_PULSE_MS    64'd200
`define IRQ_PULSE_CYCLES int'((`IRQ_PULSE_MS * `CLK_HZ) / 64'd1000)
`define XTAL_HZ         32768
`define WD_TICK_DIV     1024
`define TRIM_WAVE_DIV   64

`endif

/* include/rtc_pkg.sv */
/*
  Types shared by the real time clock register file.
  Assumes nothing of its surroundings.
*/
package rtc_pkg;
  // ==========================================================
  // Interrupt pin sequencing
  typedef enum logic {IRQ_IDLE, IRQ_PULSE} irq_state_e;
endpackage : rtc_pkg

/* verilog/rtc_register_file.sv */
/*
  Real time clock register file behind an asynchronous byte-wide memory bus.
  Assumes the bus, crystal and supply-trip pins come from outside core_clk
  and are synchronised here; the SRAM array answers the lower addresses.
*/
`timescale 1ns/100ps
`include "rtc_map.svh"

module rtc_register_file #(
  parameter int PULSE_CYCLES = `IRQ_PULSE_CYCLES,
  parameter int PRESCALE     = `XTAL_HZ
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Memory bus pins
  input  wire logic [14:0] sram_addr,
  input  wire logic        sram_ce_n,
  input  wire logic        sram_we_n,
  input  wire logic        sram_oe_n,
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq_out,
  output logic             dq_oe,
  // Timebase and supply monitor
  input  wire logic        crystal_clk,
  input  wire logic        supply_below_trip,
  // Interrupt pin
  output logic             irq_out,
  output logic             irq_oe
);

  // ==========================================================
  // Elaboration checks
  // Refused while elaborating; the prescaler term is only sixteen bits wide
  if (PULSE_CYCLES < 1) $error("PULSE_CYCLES must be at least one");
  if (PRESCALE < 2048 || PRESCALE > 32768) $error("PRESCALE out of range");

  localparam int PW = $clog2(PULSE_CYCLES + 1);

  // ==========================================================
  // Helper functions
  function automatic logic addr_hit(input logic [14:0] a);
    addr_hit = (a[14:4] == `ADDR_BLOCK);
  endfunction : addr_hit

  // One BCD step with wrap from last back to first
  function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                          input logic [7:0] first);
    if (v == last)
      bcd_step = first;
    else if (v[3:0] == 4'h9)
      bcd_step = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_step = v + 8'h01;
  endfunction : bcd_step

  // Last date of a month; leap years every fourth year
  function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      8'h02:                      month_last = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
      default:                    month_last = 8'h31;
    endcase
  endfunction : month_last

  // ==========================================================
  // Pin synchronisers
  logic [14:0] addr_s1, addr_s2;
  logic [7:0]  dq_s1, dq_s2;
  logic [4:0]  ctl_s1, ctl_s2;   // {trip, crystal, oe_n, we_n, ce_n}

  // Two flops before any logic reads a pin
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_s1 <= 15'h0000;
      addr_s2 <= 15'h0000;
      dq_s1   <= 8'h00;
      dq_s2   <= 8'h00;
      ctl_s1  <= 5'h0f;
      ctl_s2  <= 5'h0f;
    end else begin
      addr_s1 <= sram_addr;
      addr_s2 <= addr_s1;
      dq_s1   <= dq_in;
      dq_s2   <= dq_s1;
      ctl_s1  <= {supply_below_trip, crystal_clk, sram_oe_n, sram_we_n, sram_ce_n};
      ctl_s2  <= ctl_s1;
    end
  end

  // ==========================================================
  // Bus cycle decode
  logic wr_act, rd_act, wr_done, flags_read, xtal_edge, trip_edge;
  logic [14:0] addr_q;
  logic [7:0]  dq_q;
  logic        wr_q, rd_q, xtal_q, trip_q;

  assign wr_act     = !ctl_s2[0] && !ctl_s2[1];
  assign rd_act     = !ctl_s2[0] && ctl_s2[1] && !ctl_s2[2] && addr_hit(addr_s2);
  // Write lands at the end of the strobe, as on a plain SRAM
  assign wr_done    = wr_q && !wr_act && addr_hit(addr_q);
  // Flags clear when the read ends or moves away, so the host sees them first
  assign flags_read = rd_q && (addr_q == `ADDR_FLAGS) && (!rd_act || addr_s2 != addr_q);
  assign xtal_edge  = ctl_s2[3] && !xtal_q;
  assign trip_edge  = ctl_s2[4] && !trip_q;

  // ==========================================================
  // Register state
  logic [7:0]  ureg [16];
  logic [7:0]  run_sec, run_min, run_hour, run_wday, run_date, run_month, run_year, run_cent;
  logic [15:0] pre;
  logic [9:0]  wd_div;
  logic [5:0]  wd_cnt;
  logic        watchdog_expired_flag, af, pf, osc_fail_flag, cal_out, wfrz, rhold;
  logic        pending_q;
  rtc_pkg::irq_state_e irq_state;
  logic [PW-1:0] pulse_cnt;

  logic [7:0]  next_ureg [16];
  logic [7:0]  next_sec, next_min, next_hour, next_wday, next_date, next_month, next_year, next_cent;
  logic [15:0] next_pre;
  logic [9:0]  next_wd_div;
  logic [5:0]  next_wd_cnt;
  logic        next_wdf, next_af, next_pf, next_osc_fail_flag, next_cal_out, next_wfrz, next_rhold;
  logic        next_pending;
  rtc_pkg::irq_state_e next_irq_state;
  logic [PW-1:0] next_pulse_cnt;
  logic [7:0]  next_dq_out;
  logic        next_dq_oe, next_irq_out, next_irq_oe;

  // Next-state logic for timekeeping, registers, watchdog and pin
  always_comb begin
    logic [15:0] term;
    logic [7:0]  rd_byte, last_day;
    logic        sec_tick, tick32, stopped, alarm_hit, set_wdf, set_af, pending, active, wave;
    next_ureg = ureg;
    {next_sec, next_min, next_hour, next_wday} = {run_sec, run_min, run_hour, run_wday};
    {next_date, next_month, next_year, next_cent} = {run_date, run_month, run_year, run_cent};
    next_pre     = pre;
    next_wd_div  = wd_div;
    next_wd_cnt  = wd_cnt;
    next_osc_fail_flag    = osc_fail_flag;
    next_cal_out = cal_out;
    next_wfrz    = wfrz;
    next_rhold   = rhold;
    set_wdf      = 1'b0;
    set_af       = 1'b0;
    sec_tick     = 1'b0;
    tick32       = 1'b0;
    alarm_hit    = 1'b0;
    rd_byte      = 8'h00;
    pending      = 1'b0;
    active       = 1'b0;
    wave         = wd_div[$clog2(`TRIM_WAVE_DIV) - 1];
    last_day     = month_last(run_month, run_year);
    stopped      = ureg[4'h8][`TRIM_STOP_BIT];

    // Prescaler; calibration stretches or shortens the last second of each minute
    term = 16'(PRESCALE - 1);
    if (run_sec == 8'h59) begin
      if (ureg[4'h8][`TRIM_SIGN_BIT])
        term = term - {11'h000, ureg[4'h8][4:0]};
      else
        term = term + {11'h000, ureg[4'h8][4:0]};
    end
    if (xtal_edge && !stopped) begin
      next_pre    = (pre >= term) ? 16'h0000 : pre + 16'h0001;
      sec_tick    = (pre >= term);
      next_wd_div = wd_div + 10'h001;
      tick32      = (wd_div == 10'(`WD_TICK_DIV - 1));
    end

    // Counting chain; write-freeze stops it so loaded values are not disturbed
    if (sec_tick && !wfrz) begin
      next_sec = bcd_step(run_sec, 8'h59, 8'h00);
      if (run_sec == 8'h59) begin
        next_min = bcd_step(run_min, 8'h59, 8'h00);
        if (run_min == 8'h59) begin
          next_hour = bcd_step(run_hour, 8'h23, 8'h00);
          if (run_hour == 8'h23) begin
            next_wday = bcd_step(run_wday, 8'h07, 8'h01);
            next_date = bcd_step(run_date, last_day, 8'h01);
            if (run_date == last_day) begin
              next_month = bcd_step(run_month, 8'h12, 8'h01);
              if (run_month == 8'h12) begin
                next_year = bcd_step(run_year, 8'h99, 8'h00);
                if (run_year == 8'h99)
                  next_cent = bcd_step(run_cent, 8'h99, 8'h00);
              end
            end
          end
        end
      end
      // Alarm compares the new time; a set mask drops that field
      alarm_hit = (ureg[4'h2][`ALM_MASK_BIT] || ureg[4'h2][6:0] == next_sec[6:0]) &&
                  (ureg[4'h3][`ALM_MASK_BIT] || ureg[4'h3][6:0] == next_min[6:0]) &&
                  (ureg[4'h4][`ALM_MASK_BIT] || ureg[4'h4][5:0] == next_hour[5:0]) &&
                  (ureg[4'h5][`ALM_MASK_BIT] || ureg[4'h5][5:0] == next_date[5:0]);
      set_af = alarm_hit;
    end

    // Watchdog countdown on the 32 Hz tick; zero period disables it
    if (tick32 && ureg[4'h7][5:0] != 6'h00) begin
      if (wd_cnt <= 6'h01) begin
        set_wdf     = 1'b1;
        next_wd_cnt = ureg[4'h7][5:0];
      end else begin
        next_wd_cnt = wd_cnt - 6'h01;
      end
    end

    // Host writes
    if (wr_done) begin
      case (addr_q)
        `ADDR_YEARS, `ADDR_MONTHS, `ADDR_DATE, `ADDR_WEEKDAY, `ADDR_HOURS, `ADDR_MINUTES,
        `ADDR_SECONDS, `ADDR_CENTURIES: begin
          if (wfrz)
            next_ureg[addr_q[3:0]] = dq_q;
        end
        `ADDR_WATCHDOG: begin
          next_ureg[4'h7][`WD_LOCK_BIT] = dq_q[`WD_LOCK_BIT];
          if (!dq_q[`WD_LOCK_BIT])
            next_ureg[4'h7][5:0] = dq_q[5:0];
          if (dq_q[`WD_KICK_BIT])
            next_wd_cnt = dq_q[`WD_LOCK_BIT] ? ureg[4'h7][5:0] : dq_q[5:0];
        end
        `ADDR_FLAGS: begin
          next_cal_out = dq_q[`FLG_CAL_BIT];
          next_wfrz    = dq_q[`FLG_W_BIT];
          next_rhold   = dq_q[`FLG_R_BIT];
          if (!dq_q[`FLG_OSC_FAIL_FLAG_BIT])
            next_osc_fail_flag = 1'b0;
          // Releasing the freeze loads the user copy into the counters
          if (wfrz && !dq_q[`FLG_W_BIT]) begin
            {next_sec, next_min, next_hour, next_wday} = {ureg[9], ureg[10], ureg[11], ureg[12]};
            {next_date, next_month, next_year, next_cent} = {ureg[13], ureg[14], ureg[15], ureg[1]};
            next_pre = 16'h0000;
          end
        end
        default: next_ureg[addr_q[3:0]] = dq_q;
      endcase
    end

    // Visible time follows the counters unless frozen or held
    if (!wfrz && !rhold && !next_wfrz) begin
      {next_ureg[9], next_ureg[10], next_ureg[11], next_ureg[12]} = {next_sec, next_min, next_hour, next_wday};
      {next_ureg[13], next_ureg[14], next_ureg[15], next_ureg[1]} = {next_date, next_month, next_year, next_cent};
    end

    // Sticky flags; a new event beats a read clear in the same cycle
    next_wdf = (watchdog_expired_flag && !flags_read) || set_wdf;
    next_af  = (af && !flags_read) || set_af;
    next_pf  = (pf && !flags_read) || trip_edge;

    // Interrupt sources, each gated by its enable
    pending = (next_wdf && ureg[4'h6][`IRQ_WIE_BIT]) ||
              (next_af  && ureg[4'h6][`IRQ_AIE_BIT]) ||
              (next_pf  && ureg[4'h6][`IRQ_PFE_BIT]);
    next_pending   = pending;
    next_irq_state = irq_state;
    next_pulse_cnt = pulse_cnt;
    case (irq_state)
      rtc_pkg::IRQ_IDLE: begin
        if (ureg[4'h6][`IRQ_PL_BIT] && pending && !pending_q) begin
          next_irq_state = rtc_pkg::IRQ_PULSE;
          next_pulse_cnt = '0;
        end
      end
      rtc_pkg::IRQ_PULSE: begin
        next_pulse_cnt = pulse_cnt + PW'(1);
        // A flags read cuts the pulse short
        if (flags_read || pulse_cnt == PW'(PULSE_CYCLES - 1))
          next_irq_state = rtc_pkg::IRQ_IDLE;
      end
      default: next_irq_state = rtc_pkg::IRQ_IDLE;
    endcase
    active = ureg[4'h6][`IRQ_PL_BIT] ? (irq_state == rtc_pkg::IRQ_PULSE) : pending;

    // Pin drive: square wave, push-pull high, or open drain low
    if (cal_out) begin
      next_irq_out = wave;
      next_irq_oe  = 1'b1;
    end else if (ureg[4'h6][`IRQ_HL_BIT]) begin
      next_irq_out = active;
      next_irq_oe  = 1'b1;
    end else begin
      next_irq_out = 1'b0;
      next_irq_oe  = active;
    end

    // Read data; kick bit always reads back as zero
    case (addr_s2)
      `ADDR_FLAGS:    rd_byte = {watchdog_expired_flag, af, pf, osc_fail_flag, 1'b0, cal_out, wfrz, rhold};
      `ADDR_WATCHDOG: rd_byte = {1'b0, ureg[4'h7][6:0]};
      default:        rd_byte = ureg[addr_s2[3:0]];
    endcase
    next_dq_out = rd_act ? rd_byte : dq_out;
    next_dq_oe  = rd_act;
  end

  // Register everything; oscillator fail flag comes up set after power-up
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++)
        ureg[i] <= `RST_TIME;
      ureg[4'he] <= `RST_DAY_ONE;
      ureg[4'hd] <= `RST_DAY_ONE;
      ureg[4'hc] <= `RST_DAY_ONE;
      ureg[4'h8] <= `RST_TRIM;
      ureg[4'h7] <= `RST_WATCHDOG;
      ureg[4'h6] <= `RST_IRQ_CTRL;
      ureg[4'h5] <= `RST_ALARM;
      ureg[4'h4] <= `RST_ALARM;
      ureg[4'h3] <= `RST_ALARM;
      ureg[4'h2] <= `RST_ALARM;
      {run_sec, run_min, run_hour, run_year, run_cent} <= {5{`RST_TIME}};
      {run_wday, run_date, run_month} <= {3{`RST_DAY_ONE}};
      pre       <= 16'h0000;
      wd_div    <= 10'h000;
      wd_cnt    <= 6'h00;
      {watchdog_expired_flag, af, pf} <= 3'b000;
      osc_fail_flag      <= 1'b1;
      cal_out   <= 1'b0;
      wfrz      <= 1'b0;
      rhold     <= 1'b0;
      pending_q <= 1'b0;
      irq_state <= rtc_pkg::IRQ_IDLE;
      pulse_cnt <= '0;
      addr_q    <= 15'h0000;
      dq_q      <= 8'h00;
      {wr_q, rd_q, xtal_q, trip_q} <= 4'h0;
      dq_out    <= 8'h00;
      dq_oe     <= 1'b0;
      irq_out   <= 1'b0;
      irq_oe    <= 1'b0;
    end else begin
      ureg      <= next_ureg;
      {run_sec, run_min, run_hour, run_wday} <= {next_sec, next_min, next_hour, next_wday};
      {run_date, run_month, run_year, run_cent} <= {next_date, next_month, next_year, next_cent};
      pre       <= next_pre;
      wd_div    <= next_wd_div;
      wd_cnt    <= next_wd_cnt;
      {watchdog_expired_flag, af, pf} <= {next_wdf, next_af, next_pf};
      osc_fail_flag      <= next_osc_fail_flag;
      cal_out   <= next_cal_out;
      wfrz      <= next_wfrz;
      rhold     <= next_rhold;
      pending_q <= next_pending;
      irq_state <= next_irq_state;
      pulse_cnt <= next_pulse_cnt;
      addr_q    <= addr_s2;
      dq_q      <= dq_s2;
      {wr_q, rd_q, xtal_q, trip_q} <= {wr_act, rd_act, ctl_s2[3], ctl_s2[4]};
      dq_out    <= next_dq_out;
      dq_oe     <= next_dq_oe;
      irq_out   <= next_irq_out;
      irq_oe    <= next_irq_oe;
    end
  end

endmodule : rtc_register_file

/* sim/rtc_register_file_asserts.sv */
/*
  Pin-level checker for the clock register file.
  Assumes it is bound into rtc_register_file and sees only its ports.
*/
`timescale 1ns/100ps
`include "rtc_map.svh"
module rtc_register_file_checker #(
  parameter int PULSE_CYCLES = 20
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Bus pins
  input wire logic [14:0] sram_addr,
  input wire logic        sram_ce_n,
  input wire logic        sram_we_n,
  input wire logic        sram_oe_n,
  input wire logic [7:0]  dq_in,
  input wire logic [7:0]  dq_out,
  input wire logic        dq_oe,
  // Interrupt pin
  input wire logic        irq_out,
  input wire logic        irq_oe
);
  // ==========================================================
  // Pin decode and snooped interrupt setup
  logic       rd_sel, wr_sel, flag_rd, pulse_mode, cal_on, next_cal_on;
  logic [7:0] irq_ctl, next_irq_ctl, hi_cnt, next_hi_cnt;
  assign rd_sel     = !sram_ce_n && sram_we_n && !sram_oe_n && (sram_addr[14:4] == `ADDR_BLOCK);
  assign wr_sel     = !sram_ce_n && !sram_we_n;
  assign flag_rd    = rd_sel && (sram_addr[3:0] == 4'h0);
  assign pulse_mode = irq_ctl[`IRQ_HL_BIT] && irq_ctl[`IRQ_PL_BIT] && !cal_on;
  // Snoop runs ahead of the sync delay, which only loosens the bounds
  always_comb begin
    next_irq_ctl = irq_ctl;
    next_cal_on  = cal_on;
    if (wr_sel && (sram_addr == `ADDR_IRQ_CTRL)) next_irq_ctl = dq_in;
    if (wr_sel && (sram_addr == `ADDR_FLAGS)) next_cal_on = dq_in[`FLG_CAL_BIT];
    next_hi_cnt = !irq_out ? 8'h00 : ((hi_cnt == 8'hff) ? hi_cnt : hi_cnt + 8'h01);
  end
  // Registers of the snoop and the high-time counter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_ctl <= `RST_IRQ_CTRL;
      cal_on  <= 1'b0;
      hi_cnt  <= 8'h00;
    end else begin
      irq_ctl <= next_irq_ctl;
      cal_on  <= next_cal_on;
      hi_cnt  <= next_hi_cnt;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence flags_read_end;
    flag_rd ##1 !flag_rd;
  endsequence
  chk_read_drive: assert property (dq_oe == $past(rd_sel, 3))
    else $error("dq_oe does not follow a mapped read");
  chk_idle_hold: assert property (!dq_oe && !$past(dq_oe) |-> $stable(dq_out))
    else $error("dq_out changed outside a read");
  chk_write_quiet: assert property (wr_sel |-> ##3 !dq_oe)
    else $error("dq driven during a write");
  chk_pin_enable: assert property (irq_out |-> irq_oe)
    else $error("irq_out high with pin disabled");
  chk_reset_pin: assert property ($fell(rst) |=> irq_oe && !irq_out && !dq_oe)
    else $error("pins wrong after reset");
  chk_flag_clear: assert property (flags_read_end |-> ##[1:5] !irq_out)
    else $error("irq not cleared by flags read");
  chk_pulse_width: assert property (pulse_mode |-> int'(hi_cnt) <= PULSE_CYCLES)
    else $error("pulse longer than its length");
  chk_pulse_start: assert property ($rose(irq_out) && pulse_mode |-> irq_out[*8])
    else $error("pulse cut short");
endmodule : rtc_register_file_checker

bind rtc_register_file rtc_register_file_checker #(.PULSE_CYCLES(PULSE_CYCLES)) chk (
  .core_clk(core_clk), .rst(rst), .sram_addr(sram_addr), .sram_ce_n(sram_ce_n),
  .sram_we_n(sram_we_n), .sram_oe_n(sram_oe_n), .dq_in(dq_in), .dq_out(dq_out),
  .dq_oe(dq_oe), .irq_out(irq_out), .irq_oe(irq_oe)
);

/* sim/rtc_host.sv */
/*
  Host model driving the asynchronous memory bus pins.
  Assumes the bench calls its tasks from falling edges of core_clk.
*/
`timescale 1ns/100ps
module rtc_host (
  // Clock
  input  wire logic        core_clk,
  // Bus pins toward the device
  output logic      [14:0] sram_addr,
  output logic             sram_ce_n,
  output logic             sram_we_n,
  output logic             sram_oe_n,
  output logic      [7:0]  dq_in,
  // Read return
  input  wire logic [7:0]  dq_out,
  input  wire logic        dq_oe
);
  // ==========================================================
  // Idle bus: deselected, data shows the inverse of the last byte
  initial begin
    sram_addr = 15'h0000;
    sram_ce_n = 1'b1;
    sram_we_n = 1'b1;
    sram_oe_n = 1'b1;
    dq_in     = 8'hff;
  end
  // Four cycles strobed and five released, more than the three sync cycles the pins need
  task automatic bus_write(input logic [14:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sram_addr = a;
    dq_in     = d; // callers keep reserved bits at zero
    sram_ce_n = 1'b0;
    sram_we_n = 1'b0;
    repeat (4) @(negedge core_clk);
    sram_we_n = 1'b1;
    sram_ce_n = 1'b1;
    dq_in     = ~d;
    repeat (5) @(negedge core_clk);
  endtask : bus_write
  // Data taken before the strobes drop, as a real host latches it
  task automatic bus_read(input logic [14:0] a, output logic [7:0] d, output logic drv);
    @(negedge core_clk);
    sram_addr = a;
    sram_ce_n = 1'b0;
    sram_oe_n = 1'b0;
    repeat (4) @(negedge core_clk);
    d         = dq_out;
    drv       = dq_oe;
    sram_ce_n = 1'b1;
    sram_oe_n = 1'b1;
    repeat (5) @(negedge core_clk);
  endtask : bus_read
endmodule : rtc_host

/* sim/rtc_register_file_tb.sv */
/*
  Self-checking bench for the clock register file.
  Assumes the host model for bus cycles and a crystal of four core cycles.
*/
`timescale 1ns/100ps
`include "rtc_map.svh"
module rtc_register_file_tb;
  localparam int PULSE = 20;
  typedef struct packed { logic [3:0] off; logic [7:0] exp; } row_s;
  // ==========================================================
  // Clocks, pins and counters
  logic        core_clk = 1'b0, rst = 1'b1, crystal_clk = 1'b0, supply_below_trip = 1'b0;
  logic [14:0] sram_addr;
  logic        sram_ce_n, sram_we_n, sram_oe_n, dq_oe, irq_out, irq_oe, oe;
  logic [7:0]  dq_in, dq_out, rd;
  int          n_mismatch = 0, n_compared = 0, n;
  row_s        rows [16] = '{'{4'h0, 8'h10}, '{4'h1, 8'h00}, '{4'h2, 8'h80}, '{4'h3, 8'h80},
                             '{4'h4, 8'h80}, '{4'h5, 8'h80}, '{4'h6, 8'h08}, '{4'h7, 8'h00},
                             '{4'h8, 8'h00}, '{4'h9, 8'h00}, '{4'ha, 8'h00}, '{4'hb, 8'h00},
                             '{4'hc, 8'h01}, '{4'hd, 8'h01}, '{4'he, 8'h01}, '{4'hf, 8'h00}};
  always #25 core_clk = ~core_clk;
  // Crystal toggled on falling core edges, four core cycles a period, so counts are exact
  initial begin
    forever begin
      repeat (2) @(negedge core_clk);
      crystal_clk = ~crystal_clk;
    end
  end
  rtc_host host (.core_clk(core_clk), .sram_addr(sram_addr), .sram_ce_n(sram_ce_n), .sram_we_n(sram_we_n),
                 .sram_oe_n(sram_oe_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  rtc_register_file #(.PULSE_CYCLES(PULSE), .PRESCALE(2048)) dut (
    .core_clk(core_clk), .rst(rst), .sram_addr(sram_addr), .sram_ce_n(sram_ce_n), .sram_we_n(sram_we_n),
    .sram_oe_n(sram_oe_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .crystal_clk(crystal_clk),
    .supply_below_trip(supply_below_trip), .irq_out(irq_out), .irq_oe(irq_oe));
  // ==========================================================
  // Compare, wait and closing tasks
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_byte
  task automatic check_count(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_count
  task automatic expect_reg(input logic [14:0] a, input logic [7:0] m, input logic [7:0] exp);
    host.bus_read(a, rd, oe);
    check_byte(rd & m, exp);
  endtask : expect_reg
  // Bounded wait; n tells how many cycles it took
  task automatic wait_irq(input logic lvl, input int max);
    n = 0;
    while (irq_out !== lvl && n < max) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_irq
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  // Hang guard, half again the expected run
  initial begin
    repeat (95000) @(negedge core_clk);
    n_mismatch++;
    report_and_stop();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      host.bus_read({`ADDR_BLOCK, rows[i].off}, rd, oe);
      check_byte(rd, rows[i].exp);
    end
    host.bus_read(15'h7fef, rd, oe);
    check_byte({7'h00, oe}, 8'h00);
    $display("test reset done");
    // Level mode; all alarm fields masked, so each second matches
    host.bus_write(`ADDR_IRQ_CTRL, 8'h48);
    wait_irq(1'b1, 9000);
    check_byte({7'h00, irq_out}, 8'h01);
    expect_reg(`ADDR_FLAGS, 8'h40, 8'h40);
    repeat (2) @(negedge core_clk);
    check_byte({7'h00, irq_out}, 8'h00);
    expect_reg(`ADDR_FLAGS, 8'h40, 8'h00);
    $display("test level done");
    // Pulse mode; alarm on hours and seconds only, hit at the midnight wrap
    host.bus_write(`ADDR_IRQ_CTRL, 8'h4c);
    host.bus_write(`ADDR_ALM_SEC, 8'h00);
    host.bus_write(`ADDR_ALM_HOURS, 8'h00);
    host.bus_write(`ADDR_FLAGS, 8'h02);
    host.bus_write(`ADDR_SECONDS, 8'h59);
    host.bus_write(`ADDR_MINUTES, 8'h59);
    host.bus_write(`ADDR_HOURS, 8'h23);
    host.bus_write(`ADDR_YEARS, 8'h99);
    host.bus_write(`ADDR_CENTURIES, 8'h98);
    host.bus_write(`ADDR_FLAGS, 8'h00);
    wait_irq(1'b1, 9000);
    wait_irq(1'b0, 100);
    check_count(n, PULSE);
    expect_reg(`ADDR_SECONDS, 8'hff, 8'h00);
    expect_reg(`ADDR_MINUTES, 8'hff, 8'h00);
    expect_reg(`ADDR_HOURS, 8'hff, 8'h00);
    expect_reg(`ADDR_YEARS, 8'hff, 8'h99);
    expect_reg(`ADDR_CENTURIES, 8'hff, 8'h98);
    expect_reg(`ADDR_FLAGS, 8'h40, 8'h40);
    $display("test time done");
    // Watchdog of two ticks; locked kicks must not change it
    host.bus_write(`ADDR_IRQ_CTRL, 8'h88);
    host.bus_write(`ADDR_WATCHDOG, 8'h82);
    expect_reg(`ADDR_WATCHDOG, 8'hff, 8'h02);
    repeat (3) begin
      repeat (3000) @(negedge core_clk);
      host.bus_write(`ADDR_WATCHDOG, 8'hc5);
    end
    check_byte({7'h00, irq_out}, 8'h00);
    wait_irq(1'b1, 8600);
    check_byte({7'h00, irq_out}, 8'h01);
    expect_reg(`ADDR_FLAGS, 8'h80, 8'h80);
    expect_reg(`ADDR_WATCHDOG, 8'h3f, 8'h02);
    host.bus_write(`ADDR_WATCHDOG, 8'h80);
    repeat (9000) @(negedge core_clk);
    check_byte({7'h00, irq_out}, 8'h00);
    expect_reg(`ADDR_FLAGS, 8'h80, 8'h00);
    $display("test watchdog done");
    // Supply trip raises the power-loss flag once
    host.bus_write(`ADDR_IRQ_CTRL, 8'h28);
    supply_below_trip = 1'b1;
    wait_irq(1'b1, 20);
    check_byte({7'h00, irq_out}, 8'h01);
    expect_reg(`ADDR_FLAGS, 8'h20, 8'h20);
    expect_reg(`ADDR_FLAGS, 8'h20, 8'h00);
    supply_below_trip = 1'b0;
    $display("test supply done");
    // Trim wave: 32 crystal periods high
    host.bus_write(`ADDR_FLAGS, 8'h04);
    wait_irq(1'b0, 300);
    wait_irq(1'b1, 300);
    wait_irq(1'b0, 300);
    check_count(n, 128);
    host.bus_write(`ADDR_FLAGS, 8'h00);
    $display("test trim done");
    // Hold keeps the visible copy while counting goes on; stop bit halts it
    host.bus_write(`ADDR_FLAGS, 8'h02);
    host.bus_write(`ADDR_SECONDS, 8'h10);
    host.bus_write(`ADDR_FLAGS, 8'h01);
    repeat (8300) @(negedge core_clk);
    expect_reg(`ADDR_SECONDS, 8'hff, 8'h10);
    host.bus_write(`ADDR_TRIM, 8'h80);
    host.bus_write(`ADDR_FLAGS, 8'h00);
    expect_reg(`ADDR_SECONDS, 8'hff, 8'h11);
    repeat (8300) @(negedge core_clk);
    expect_reg(`ADDR_SECONDS, 8'hff, 8'h11);
    host.bus_write(`ADDR_TRIM, 8'h00);
    $display("test hold done");
    report_and_stop();
  end
endmodule : rtc_register_file_tb
